// *** pmw_ctrl.sv ***
`timescale 1ns/100ps
module pmw_ctrl #(
  parameter int SUB_PERIOD_CYC_P = pmw_pkg::SUB_PERIOD_CYC
) (
  // Clock and reset.
  input  wire logic                       MCLK_I,
  input  wire logic                       RST_N_I,
  // CPU instructions and clock control.
  input  wire logic                       HALT_I,
  input  wire logic                       CLEAR_WATCHDOG_INSTR_I,
  input  wire logic [pmw_pkg::SEL_W-1:0]  SYSCLK_SELECT_I,
  input  wire logic                       HS_OSC_HALT_KEEP_I,
  input  wire logic                       LS_OSC_HALT_KEEP_I,
  input  wire logic                       HS_OSC_EN_I,
  input  wire logic                       HS_FREQ_CHG_I,
  // Oscillator status.
  input  wire logic                       HS_OSC_READY_I,
  input  wire logic                       LS_OSC_READY_I,
  // Wake sources, interrupt enable, stack state and watchdog enable.
  input  wire logic [pmw_pkg::PA_W-1:0]   PORTA_I,
  input  wire logic [pmw_pkg::PA_W-1:0]   PORTA_WAKE_ENABLE_I,
  input  wire logic                       EXT_RESET_PIN_N_I,
  input  wire logic [pmw_pkg::INT_W-1:0]  INT_REQ_I,
  input  wire logic                       INT_ENABLE_I,
  input  wire logic                       STACK_FULL_I,
  input  wire logic                       WDT_OVF_I,
  input  wire logic                       WDT_EN_I,
  // Clock outputs.
  output logic                            SYS_TICK_O,
  output logic [pmw_pkg::SEL_W-1:0]       SYSCLK_ACTIVE_O,
  output logic                            SLOW_MODE_O,
  output logic                            SWITCH_BUSY_O,
  output logic                            HS_OSC_ON_O,
  output logic                            LS_OSC_ON_O,
  output logic                            HS_OSC_STABLE_FLAG_O,
  // Power state, flags and watchdog control.
  output logic                            CPU_HALTED_O,
  output logic [1:0]                      HALT_MODE_O,
  output logic                            POWERDOWN_FLAG_O,
  output logic                            WDT_TIMEOUT_FLAG_O,
  output logic                            WDT_CLEAR_O,
  output logic                            WDT_RUN_O,
  // Wake actions.
  output logic                            FULL_RESET_O,
  output logic                            PC_SP_RESET_O,
  output logic                            RESUME_NEXT_O,
  output logic                            INT_SERVICE_O
);
  import pmw_pkg::*;

  // ==========================================================================
  // State.
  pmw_state_e             state_q, state_d;
  pmw_wake_e              cause_q, cause_d;
  logic [SEL_W-1:0]       sel_act_q, sel_tgt_q;
  logic [CNT_W-1:0]       sw_cnt_q, div_cnt_q;
  logic                   keep_h_q, keep_l_q;
  logic [INT_W-1:0]       int_mask_q;
  logic [PA_W-1:0]        pa_s1_q, pa_s2_q, pa_s3_q;
  logic                   rst_s1_q, rst_s2_q;
  logic                   hs_on_q, ls_on_q, hs_stable_q, tick_q;
  logic                   pdf_q, to_q, wdt_clr_q, wdt_run_q;
  logic                   full_rst_q, pcsp_rst_q, resume_q, int_srv_q;
  logic                   slow_q, busy_q, halted_q;

  // ==========================================================================
  // Clock periods in master cycles.
  function automatic logic [CNT_W-1:0] period_cyc(input logic [SEL_W-1:0] sel);
    logic [CNT_W-1:0] p;
    p = CNT_W'(1) << sel;
    if (sel == SEL_SLOW) begin
      p = CNT_W'(SUB_PERIOD_CYC_P);
    end
    return p;
  endfunction

  wire [CNT_W-1:0] cur_per  = period_cyc(sel_act_q);
  wire [CNT_W-1:0] tgt_per  = period_cyc(SYSCLK_SELECT_I);
  wire [CNT_W-1:0] sw_delay = CNT_W'(SW_BASE_PER) * cur_per
                            + ((CNT_W'(SW_CUR_HALVES) * cur_per
                            + CNT_W'(SW_TAR_HALVES) * tgt_per + CNT_W'(1)) >> 1);

  // ==========================================================================
  // Decoding.
  wire in_run    = (state_q == ST_RUN);
  wire in_switch = (state_q == ST_SWITCH);
  wire in_halt   = (state_q == ST_HALT);
  wire in_wake   = (state_q == ST_WAKE);
  wire slow_act  = (sel_act_q == SEL_SLOW);
  wire slow_tgt  = (sel_tgt_q == SEL_SLOW);
  wire halt_go   = in_run & HALT_I;
  wire sw_go     = in_run & ~HALT_I & (SYSCLK_SELECT_I != sel_act_q);
  wire tgt_ready = slow_tgt ? LS_OSC_READY_I : hs_stable_q;
  wire sw_done   = in_switch & (sw_cnt_q == '0) & tgt_ready;
  wire orig_ok   = slow_act ? LS_OSC_READY_I : hs_stable_q;
  wire pa_fall   = |(pa_s3_q & ~pa_s2_q & PORTA_WAKE_ENABLE_I);
  wire rst_wake  = ~rst_s2_q;
  wire int_wake  = |(INT_REQ_I & int_mask_q);
  wire any_wake  = pa_fall | rst_wake | int_wake | WDT_OVF_I;
  wire sys_run   = in_run | in_switch;
  wire hs_want   = in_halt ? keep_h_q
                 : (~slow_act | HS_OSC_EN_I | (in_switch & ~slow_tgt));
  wire ls_want   = WDT_EN_I | (in_halt ? keep_l_q
                 : (slow_act | (in_switch & slow_tgt)));
  wire [SEL_W-1:0] sel_act_d = sw_done ? sel_tgt_q : sel_act_q;
  wire slow_d    = ls_want & (sel_act_d == SEL_SLOW);
  wire busy_d    = (state_d == ST_SWITCH);
  wire halted_d  = (state_d == ST_HALT) | (state_d == ST_WAKE);

  // ==========================================================================
  // Next state.
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    unique case (state_q)
      ST_RUN: begin
        if (halt_go) begin
          state_d = ST_HALT;
        end else if (sw_go) begin
          state_d = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        if (sw_done) begin
          state_d = ST_RUN;
        end
      end
      ST_HALT: begin
        if (any_wake) begin
          state_d = ST_WAKE;
          if (rst_wake) begin
            cause_d = WK_RST;
          end else if (WDT_OVF_I) begin
            cause_d = WK_WDT;
          end else if (int_wake) begin
            cause_d = WK_INT;
          end else begin
            cause_d = WK_PORT;
          end
        end
      end
      ST_WAKE: begin
        if (orig_ok) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ==========================================================================
  // Control registers.
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q    <= ST_RUN;
      cause_q    <= WK_PORT;
      sel_act_q  <= SEL_POR;
      sel_tgt_q  <= SEL_POR;
      sw_cnt_q   <= '0;
      keep_h_q   <= 1'b0;
      keep_l_q   <= 1'b0;
      int_mask_q <= '0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      if (sw_go) begin
        sel_tgt_q <= SYSCLK_SELECT_I;
        sw_cnt_q  <= sw_delay;
      end else if (in_switch && sw_cnt_q != '0) begin
        sw_cnt_q <= sw_cnt_q - CNT_W'(1);
      end
      if (sw_done) begin
        sel_act_q <= sel_tgt_q;
      end
      if (halt_go) begin
        keep_h_q   <= HS_OSC_HALT_KEEP_I;
        keep_l_q   <= LS_OSC_HALT_KEEP_I;
        int_mask_q <= ~INT_REQ_I;
      end
    end
  end

  // ==========================================================================
  // Synchronisers for the port A and reset pin wake inputs.
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pa_s1_q  <= '1;
      pa_s2_q  <= '1;
      pa_s3_q  <= '1;
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
    end else begin
      pa_s1_q  <= PORTA_I;
      pa_s2_q  <= pa_s1_q;
      pa_s3_q  <= pa_s2_q;
      rst_s1_q <= EXT_RESET_PIN_N_I;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ==========================================================================
  // System clock divider and oscillator control.
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_cnt_q   <= '0;
      tick_q      <= 1'b0;
      hs_on_q     <= 1'b0;
      ls_on_q     <= 1'b1;
      hs_stable_q <= 1'b0;
    end else begin
      if (!sys_run || div_cnt_q >= cur_per - CNT_W'(1)) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= div_cnt_q + CNT_W'(1);
      end
      tick_q  <= sys_run & (div_cnt_q == '0);
      hs_on_q <= hs_want;
      ls_on_q <= ls_want;
      if (!hs_on_q || HS_FREQ_CHG_I) begin
        hs_stable_q <= 1'b0;
      end else if (HS_OSC_READY_I) begin
        hs_stable_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Flags, watchdog control and wake actions.
  wire wake_end = in_wake & orig_ok;
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pdf_q      <= 1'b0;
      to_q       <= 1'b0;
      wdt_clr_q  <= 1'b0;
      wdt_run_q  <= 1'b0;
      full_rst_q <= 1'b0;
      pcsp_rst_q <= 1'b0;
      resume_q   <= 1'b0;
      int_srv_q  <= 1'b0;
      slow_q     <= 1'b1;
      busy_q     <= 1'b0;
      halted_q   <= 1'b0;
    end else begin
      if (halt_go) begin
        pdf_q <= 1'b1;
      end else if (CLEAR_WATCHDOG_INSTR_I) begin
        pdf_q <= 1'b0;
      end
      if (WDT_OVF_I) begin
        to_q <= 1'b1;
      end else if (halt_go) begin
        to_q <= 1'b0;
      end
      wdt_clr_q  <= halt_go | CLEAR_WATCHDOG_INSTR_I;
      wdt_run_q  <= WDT_EN_I;
      full_rst_q <= wake_end & (cause_q == WK_RST);
      pcsp_rst_q <= wake_end & (cause_q == WK_WDT);
      resume_q   <= wake_end & ((cause_q == WK_PORT)
                  | ((cause_q == WK_INT) & (~INT_ENABLE_I | STACK_FULL_I)));
      int_srv_q  <= wake_end & (cause_q == WK_INT) & INT_ENABLE_I & ~STACK_FULL_I;
      slow_q     <= slow_d;
      busy_q     <= busy_d;
      halted_q   <= halted_d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign SYS_TICK_O           = tick_q;
  assign SYSCLK_ACTIVE_O      = sel_act_q;
  assign SLOW_MODE_O          = slow_q;
  assign SWITCH_BUSY_O        = busy_q;
  assign HS_OSC_ON_O          = hs_on_q;
  assign LS_OSC_ON_O          = ls_on_q;
  assign HS_OSC_STABLE_FLAG_O = hs_stable_q;
  assign CPU_HALTED_O         = halted_q;
  assign HALT_MODE_O          = {keep_h_q, keep_l_q};
  assign POWERDOWN_FLAG_O     = pdf_q;
  assign WDT_TIMEOUT_FLAG_O   = to_q;
  assign WDT_CLEAR_O          = wdt_clr_q;
  assign WDT_RUN_O            = wdt_run_q;
  assign FULL_RESET_O         = full_rst_q;
  assign PC_SP_RESET_O        = pcsp_rst_q;
  assign RESUME_NEXT_O        = resume_q;
  assign INT_SERVICE_O        = int_srv_q;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_halt_taken;
    in_run && HALT_I;
  endsequence

  AST_SLOW_SEL: assert property (sw_done && slow_tgt |=> sel_act_q == SEL_SLOW)
    else $error("Slow selection did not take effect.");
  AST_SLOW_WAITS_LS: assert property (in_switch && slow_tgt && !LS_OSC_READY_I
    |=> state_q == ST_SWITCH)
    else $error("Slow switch completed before the sub oscillator was stable.");
  AST_FAST_DIV1: assert property (in_run && sel_act_q == 3'h0 && $past(in_run)
    |=> SYS_TICK_O)
    else $error("Undivided fast clock missed a tick.");
  AST_HS_FLAG_CLEAR: assert property ($rose(hs_on_q) |-> !hs_stable_q)
    else $error("Stable flag high when the fast oscillator starts.");
  AST_SLEEP_ENTRY: assert property (s_halt_taken and (!HS_OSC_HALT_KEEP_I
    && !LS_OSC_HALT_KEEP_I && !WDT_EN_I) |=> ##1 !HS_OSC_ON_O && !LS_OSC_ON_O)
    else $error("Sleep left an oscillator running.");
  AST_IDLE_SUB: assert property (s_halt_taken and (!HS_OSC_HALT_KEEP_I
    && LS_OSC_HALT_KEEP_I) |=> ##1 !HS_OSC_ON_O && LS_OSC_ON_O)
    else $error("Idle-sub clocks wrong.");
  AST_IDLE_BOTH: assert property (s_halt_taken and (HS_OSC_HALT_KEEP_I
    && LS_OSC_HALT_KEEP_I) |=> ##1 HS_OSC_ON_O && LS_OSC_ON_O && !SYS_TICK_O)
    else $error("Idle-both clocks wrong.");
  AST_IDLE_HIGH: assert property (s_halt_taken and (HS_OSC_HALT_KEEP_I
    && !LS_OSC_HALT_KEEP_I && !WDT_EN_I) |=> ##1 HS_OSC_ON_O && !LS_OSC_ON_O)
    else $error("Idle-high clocks wrong.");
  AST_HALT_FLAGS: assert property (s_halt_taken and (!WDT_OVF_I)
    |=> POWERDOWN_FLAG_O && !WDT_TIMEOUT_FLAG_O && WDT_CLEAR_O && CPU_HALTED_O)
    else $error("Halt did not set the power-down flags.");
  AST_PDF_CLEAR: assert property (CLEAR_WATCHDOG_INSTR_I && !halt_go
    |=> !POWERDOWN_FLAG_O ##0 WDT_CLEAR_O)
    else $error("Clear-watchdog did not clear the power-down flag.");
  AST_WDT_WAKE: assert property (in_halt && WDT_OVF_I && !rst_wake
    |=> WDT_TIMEOUT_FLAG_O ##0 cause_q == WK_WDT)
    else $error("Watchdog wake did not set timeout.");
  AST_SWITCH_DELAY: assert property (sw_go |=> SWITCH_BUSY_O [*4])
    else $error("Clock switch ended early.");
  AST_WAKE_HOLD: assert property (in_wake && !orig_ok |=> CPU_HALTED_O && !SYS_TICK_O)
    else $error("Execution resumed before the oscillator was stable.");
  AST_PENDING_INT: assert property (in_halt && !pa_fall && !rst_wake && !WDT_OVF_I
    && ((INT_REQ_I & int_mask_q) == '0) |=> in_halt)
    else $error("Pending interrupt woke the device.");

endmodule

// *** pmw_pkg.sv ***
package pmw_pkg;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SUB_PERIOD_NS  = 31250;
  localparam int SUB_PERIOD_CYC = (SUB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_BASE_PER    = 4;
  localparam int SW_CUR_HALVES  = 3;
  localparam int SW_TAR_HALVES  = 1;

  // ==========================================================================
  // Widths.
  localparam int SEL_W = 3;
  localparam int PA_W  = 8;
  localparam int INT_W = 4;
  localparam int CNT_W = 20;

  // ==========================================================================
  // Clock selection codes, reset value and halt mode codes.
  localparam logic [2:0] SEL_SLOW    = 3'h7;
  localparam logic [2:0] SEL_POR     = 3'h7;
  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] MODE_IDLE_S = 2'h1;
  localparam logic [1:0] MODE_IDLE_H = 2'h2;
  localparam logic [1:0] MODE_IDLE_B = 2'h3;

  // ==========================================================================
  // Controller states and wake causes.
  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_SWITCH = 4'h2,
    ST_HALT   = 4'h4,
    ST_WAKE   = 4'h8
  } pmw_state_e;

  typedef enum logic [3:0] {
    WK_PORT = 4'h1,
    WK_INT  = 4'h2,
    WK_WDT  = 4'h4,
    WK_RST  = 4'h8
  } pmw_wake_e;

endpackage

// *** pmw_osc_model.sv ***
`timescale 1ns/100ps
// ============================================================================
// Oscillator model: each ready rises a fixed count after its enable.
module pmw_osc_model #(
  parameter int HS_DLY_P = 6,
  parameter int LS_DLY_P = 4
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Oscillator control.
  input  wire logic hs_on_i,
  input  wire logic ls_on_i,
  input  wire logic hs_chg_i,
  // Oscillator status.
  output logic      hs_ready_o,
  output logic      ls_ready_o
);
  int hs_cnt_q;
  int ls_cnt_q;
  // A frequency change or a stop restarts the settling count.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_cnt_q <= 0;
      ls_cnt_q <= 0;
    end else begin
      hs_cnt_q <= (!hs_on_i || hs_chg_i) ? 0 : (hs_cnt_q < HS_DLY_P) ? hs_cnt_q + 1 : hs_cnt_q;
      ls_cnt_q <= (!ls_on_i) ? 0 : (ls_cnt_q < LS_DLY_P) ? ls_cnt_q + 1 : ls_cnt_q;
    end
  end
  assign hs_ready_o = hs_on_i && (hs_cnt_q >= HS_DLY_P);
  assign ls_ready_o = ls_on_i && (ls_cnt_q >= LS_DLY_P);
endmodule

// *** power_mode_wake_control_tb_top.sv ***
`timescale 1ns/100ps
module power_mode_wake_control_tb_top;
  import pmw_pkg::*;
  // ==========================================================================
  // Signals.
  logic             mclk = 0, rst_n = 0, halt = 0, clr = 0, fchg = 0, hen = 0, wen = 0;
  logic             hs_keep = 0, ls_keep = 0, ext_n = 1, int_en = 0, stk = 0, wovf = 0;
  logic [SEL_W-1:0] sel = SEL_POR;
  logic [PA_W-1:0]  pa = 8'hff, pa_en = 8'h00;
  logic [INT_W-1:0] irq = 4'h0;
  logic             hs_rdy, ls_rdy, tick_o, slow, busy, hs_on, ls_on, hs_stb, halted;
  logic             powerdown_flag, to, wclr, wrun, fres, pcsp, resume, isvc;
  logic [SEL_W-1:0] act;
  logic [1:0]       hmode;
  int               bad_count = 0;
  int               n_checks = 0;
  int               n;
  always #5 mclk = ~mclk;
  // ==========================================================================
  // Design and partner.
  pmw_ctrl #(.SUB_PERIOD_CYC_P(8)) pmw_ctrl_i (
    .MCLK_I(mclk), .RST_N_I(rst_n), .HALT_I(halt), .CLEAR_WATCHDOG_INSTR_I(clr),
    .SYSCLK_SELECT_I(sel), .HS_OSC_HALT_KEEP_I(hs_keep), .LS_OSC_HALT_KEEP_I(ls_keep),
    .HS_OSC_EN_I(hen), .HS_FREQ_CHG_I(fchg), .HS_OSC_READY_I(hs_rdy),
    .LS_OSC_READY_I(ls_rdy), .PORTA_I(pa), .PORTA_WAKE_ENABLE_I(pa_en),
    .EXT_RESET_PIN_N_I(ext_n), .INT_REQ_I(irq), .INT_ENABLE_I(int_en),
    .STACK_FULL_I(stk), .WDT_OVF_I(wovf), .WDT_EN_I(wen), .SYS_TICK_O(tick_o),
    .SYSCLK_ACTIVE_O(act), .SLOW_MODE_O(slow), .SWITCH_BUSY_O(busy),
    .HS_OSC_ON_O(hs_on), .LS_OSC_ON_O(ls_on), .HS_OSC_STABLE_FLAG_O(hs_stb),
    .CPU_HALTED_O(halted), .HALT_MODE_O(hmode), .POWERDOWN_FLAG_O(powerdown_flag),
    .WDT_TIMEOUT_FLAG_O(to), .WDT_CLEAR_O(wclr), .WDT_RUN_O(wrun),
    .FULL_RESET_O(fres), .PC_SP_RESET_O(pcsp), .RESUME_NEXT_O(resume),
    .INT_SERVICE_O(isvc));
  pmw_osc_model pmw_osc_model_i (
    .clk_i(mclk), .rst_n_i(rst_n), .hs_on_i(hs_on), .ls_on_i(ls_on),
    .hs_chg_i(fchg), .hs_ready_o(hs_rdy), .ls_ready_o(ls_rdy));
  // ==========================================================================
  // Tasks.
  task automatic tick(input int k = 1);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic chk_min(input string nm, input int exp, input int got);
    n_checks++;
    if (got < exp) begin
      bad_count++;
      $display("unexpected %s expected at least %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic switch_to(input logic [2:0] s, output int cyc);
    sel = s;
    tick(2);
    cyc = 2;
    while (busy === 1'b1 && cyc < 2000) begin
      tick();
      cyc++;
    end
  endtask
  task automatic do_halt(input logic [1:0] m);
    {hs_keep, ls_keep} = m;
    halt = 1;
    tick();
    halt = 0;
    chk("halted", 8'h01, halted);
    chk("powerdown", 8'h01, powerdown_flag);
    chk("timeout", 8'h00, to);
    chk("wdt clear", 8'h01, wclr);
    tick(3);
    chk("halt mode", m, hmode);
    chk("hs osc on", m[1], hs_on);
    chk("ls osc on", m[0], ls_on);
  endtask
  task automatic wake_exp(input logic [3:0] exp);
    int k;
    k = 0;
    while ({fres, pcsp, resume, isvc} == 4'h0 && k < 300) begin
      tick();
      k++;
    end
    chk("wake action", exp, {fres, pcsp, resume, isvc});
    tick();
    chk("halted after wake", 8'h00, halted);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests.
  initial begin
    tick(16);
    rst_n = 1;
    tick();
    chk("active", SEL_POR, act);
    chk("slow", 8'h01, slow);
    chk("powerdown", 8'h00, powerdown_flag);
    switch_to(3'h0, n);
    chk("active", 8'h00, act);
    chk("slow", 8'h00, slow);
    chk("hs stable", 8'h01, hs_stb);
    chk_min("switch cycles", 4 * 8 + (3 * 8 + 1 + 1) / 2, n);
    $display("test switch to fast done");
    fchg = 1;
    tick();
    fchg = 0;
    tick();
    chk("hs stable", 8'h00, hs_stb);
    n = 0;
    while (hs_stb !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk("hs stable", 8'h01, hs_stb);
    n = 0;
    repeat (8) begin
      tick();
      if (tick_o === 1'b1) begin
        n++;
      end
    end
    chk("fast ticks", 8'h08, 8'(n));
    $display("test frequency change done");
    pa_en = 8'h01;
    for (int m = 0; m < 4; m++) begin
      do_halt(2'(m));
      pa = 8'hfd;
      tick(10);
      chk("halted", 8'h01, halted);
      pa = 8'hfc;
      wake_exp(4'h2);
      pa = 8'hff;
      tick(4);
    end
    $display("test halt modes done");
    clr = 1;
    tick();
    clr = 0;
    tick();
    chk("powerdown", 8'h00, powerdown_flag);
    do_halt(2'h3);
    wovf = 1;
    tick();
    wovf = 0;
    wake_exp(4'h4);
    chk("timeout", 8'h01, to);
    chk("powerdown", 8'h01, powerdown_flag);
    do_halt(2'h3);
    ext_n = 0;
    wake_exp(4'h8);
    ext_n = 1;
    $display("test reset wakes done");
    irq = 4'h1;
    tick(2);
    do_halt(2'h3);
    tick(20);
    chk("halted", 8'h01, halted);
    irq = 4'h3;
    wake_exp(4'h2);
    irq = 4'h0;
    int_en = 1;
    stk = 1;
    tick(2);
    do_halt(2'h3);
    irq = 4'h2;
    wake_exp(4'h2);
    irq = 4'h0;
    stk = 0;
    tick(2);
    do_halt(2'h3);
    irq = 4'h4;
    wake_exp(4'h1);
    irq = 4'h0;
    $display("test interrupt wakes done");
    switch_to(SEL_SLOW, n);
    chk("active", SEL_SLOW, act);
    chk("slow", 8'h01, slow);
    chk_min("switch cycles", 4 * 1 + (3 * 1 + 8 + 1) / 2, n);
    n = 0;
    repeat (32) begin
      tick();
      if (tick_o === 1'b1) begin
        n++;
      end
    end
    chk("slow ticks", 8'h04, 8'(n));
    $display("test switch to slow done");
    hen = 1;
    tick(2);
    chk("hs osc on", 8'h01, hs_on);
    chk("hs stable", 8'h00, hs_stb);
    n = 0;
    while (hs_stb !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk("hs stable", 8'h01, hs_stb);
    hen = 0;
    tick(2);
    chk("hs stable", 8'h00, hs_stb);
    wen = 1;
    tick(2);
    chk("wdt run", 8'h01, wrun);
    do_halt(2'h1);
    chk("wdt run", 8'h01, wrun);
    wovf = 1;
    tick();
    wovf = 0;
    wake_exp(4'h4);
    chk("powerdown", 8'h01, powerdown_flag);
    rst_n = 0;
    tick(2);
    rst_n = 1;
    tick();
    chk("powerdown", 8'h00, powerdown_flag);
    chk("active", SEL_POR, act);
    $display("test enables and reset done");
    stop_test();
  end
  initial begin
    #300us;
    bad_count++;
    stop_test();
  end
endmodule
